// File: ocws_pkg.sv
// Package with constants, states and carrier types for the overcurrent window sequencer
package ocws_pkg;
    // Timing figures
    localparam int CLK_PERIOD_NS = 100;                       // Core clock period
    localparam int TICK_NS = 10;                              // On-time quantum
    localparam int TICKS_PER_CLK = CLK_PERIOD_NS / TICK_NS;   // Ticks added per clock
    // Widths
    localparam int CODE_W = 6;                                // Trip setting code width
    localparam int REF_W = CODE_W + 1;                        // Doubled reference width
    localparam int TICK_W = 16;                               // On-time tick count width
    // Soft-start accounting
    localparam int SS_STEPS = 32;                             // Steps in one soft-start
    localparam int RETRY_SS = 4;                              // Soft-starts waited on retry
    localparam int WAIT_STEPS = SS_STEPS * RETRY_SS;          // Steps in retry wait
    localparam int WAIT_W = 8;                                // Wait counter width
    // Sized constants
    localparam logic [TICK_W-1:0] TICK_INC = TICK_W'(TICKS_PER_CLK);
    localparam logic [TICK_W-1:0] TICK_ZERO = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00;
    localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 8'h00;
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(WAIT_STEPS - 1);
    localparam int WIN_NUM = 3;                               // Window numerator
    localparam int WIN_SHIFT = 2;                             // Window divides by four
    localparam int HALF_SHIFT = 1;                            // Half pulse divides by two

    // Sequencer states
    typedef enum logic [2:0] {
        OCWS_CAPTURE,
        OCWS_RUN,
        OCWS_FINISH,
        OCWS_HALF_ARM,
        OCWS_HALF,
        OCWS_WAIT
    } ocws_state_t;

    // Gate drive pair
    typedef struct packed {
        logic hs;
        logic ls;
    } ocws_gate_t;
endpackage

// File: ocws_top.sv
// Overcurrent window sequencer: on-time window, trip detect, reference and retry sequencing
module ocws_top
    import ocws_pkg::*;
(
    input wire logic core_clk_i,                    // 10 MHz core clock
    input wire logic rstn_i,                        // Synchronous reset, active low
    input wire logic pwm_on_i,                      // High-side demand from PWM logic
    input wire logic sense_cmp_i,                   // Switch node above trip reference
    input wire logic set_cmp_i,                     // Set comparator crossed resistor level
    input wire logic ss_active_i,                   // Soft-start in progress
    input wire logic ss_step_i,                     // One soft-start step pulse
    output logic hs_gate_o,                         // High-side gate drive
    output logic ls_gate_o,                         // Low-side gate drive
    output logic [REF_W-1:0] trip_ref_o,            // Code to trip reference converter
    output logic [CODE_W-1:0] set_dac_o,            // Code to set comparator during capture
    output logic [CODE_W-1:0] trip_setting_code_o,  // Stored trip setting code
    output logic [TICK_W-1:0] window_limit_o,       // Sensing window limit in ticks
    output logic overcurrent_trip_o,                // One-cycle pulse on trip
    output logic retry_start_o                      // One-cycle pulse to start soft-start
);

    // Ceiling-free window computation used at each turn-off outside the half pulse
    function automatic logic [TICK_W-1:0] ocws_three_quarter(input logic [TICK_W-1:0] t);
        logic [TICK_W+1:0] p;
        p = (TICK_W+2)'(t) * (TICK_W+2)'(WIN_NUM);
        return TICK_W'(p >> WIN_SHIFT);
    endfunction

    ocws_state_t state;                 // Sequencer state
    ocws_gate_t gate;                   // Registered gate drive
    logic sense_m, sense_s;             // Sense comparator synchroniser
    logic set_m, set_s;                 // Set comparator synchroniser
    logic pwm_d;                        // Previous PWM demand
    logic [TICK_W-1:0] on_ticks;        // Ticks of the present on-time
    logic [TICK_W-1:0] last_ton;        // Latched final on-time count
    logic [TICK_W-1:0] window_limit;    // Window for the present cycle
    logic [TICK_W-1:0] half_ticks;      // Ticks of the final half pulse
    logic [WAIT_W-1:0] wait_cnt;        // Soft-start steps waited
    logic [CODE_W-1:0] code;            // Trip setting code
    logic [CODE_W-1:0] dac_cnt;         // Capture counter
    logic pwm_rise, pwm_fall;           // PWM edges
    logic in_window;                    // Sense accepted this cycle
    logic trip_hit;                     // Trip detected this cycle
    logic half_done;                    // Half pulse complete

    // Edges of the PWM demand (same clock, no synchroniser)
    assign pwm_rise = pwm_on_i & ~pwm_d;
    assign pwm_fall = ~pwm_on_i & pwm_d;
    // Window is open while the high-side demand is on and inside 3/4 of prior on-time
    assign in_window = pwm_on_i && (on_ticks < window_limit);
    // Trip only in run state while the window is open
    assign trip_hit = (state == OCWS_RUN) && in_window && sense_s;
    assign half_done = half_ticks >= (last_ton >> HALF_SHIFT);

    // Two-stage synchronisers for the comparators
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            sense_m <= 1'b0;
            sense_s <= 1'b0;
            set_m <= 1'b0;
            set_s <= 1'b0;
        end else begin
            sense_m <= sense_cmp_i;
            sense_s <= sense_m;
            set_m <= set_cmp_i;
            set_s <= set_m;
        end
    end

    // Previous PWM level
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pwm_d <= 1'b0;
        end else begin
            pwm_d <= pwm_on_i;
        end
    end

    // On-time tick counter: load one clock of ticks at turn-on, count while on, latch at turn-off outside the half pulse
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            on_ticks <= TICK_ZERO;
            last_ton <= TICK_ZERO;
        end else if (pwm_rise) begin
            on_ticks <= TICK_INC;
        end else if (pwm_on_i) begin
            on_ticks <= on_ticks + TICK_INC;
        end else if (pwm_fall && state != OCWS_HALF) begin
            last_ton <= on_ticks;
        end
    end

    // Window limit for the following cycle
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            window_limit <= TICK_ZERO;
        end else if (pwm_fall && state != OCWS_HALF) begin
            window_limit <= ocws_three_quarter(on_ticks);
        end
    end

    // Trip code capture by counting up until the set comparator crosses
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            dac_cnt <= CODE_ZERO;
            code <= CODE_ZERO;
        end else if (state == OCWS_CAPTURE) begin
            if (set_s || dac_cnt == CODE_MAX) begin
                code <= dac_cnt;
            end else begin
                dac_cnt <= dac_cnt + 6'h01;
            end
        end
    end

    // Half pulse tick counter
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            half_ticks <= TICK_ZERO;
        end else if (state == OCWS_HALF) begin
            half_ticks <= half_ticks + TICK_INC;
        end else begin
            half_ticks <= TICK_ZERO;
        end
    end

    // Retry wait counts soft-start steps
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wait_cnt <= WAIT_ZERO;
        end else if (state != OCWS_WAIT) begin
            wait_cnt <= WAIT_ZERO;
        end else if (ss_step_i) begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end

    // Sequencer
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state <= OCWS_CAPTURE;
        end else begin
            case (state)
                // Trip code capture before any switching
                OCWS_CAPTURE: begin
                    if (set_s || dac_cnt == CODE_MAX) begin
                        state <= OCWS_RUN;
                    end
                end
                // Normal switching
                OCWS_RUN: begin
                    if (trip_hit) begin
                        state <= OCWS_FINISH;
                    end
                end
                // Finish present cycle
                OCWS_FINISH: begin
                    if (!pwm_on_i) begin
                        state <= OCWS_HALF_ARM;
                    end
                end
                // Await next turn-on for the half pulse
                OCWS_HALF_ARM: begin
                    if (pwm_on_i) begin
                        state <= OCWS_HALF;
                    end
                end
                // Half-length final pulse
                OCWS_HALF: begin
                    if (half_done) begin
                        state <= OCWS_WAIT;
                    end
                end
                // Both gates off for four soft-starts
                OCWS_WAIT: begin
                    if (ss_step_i && wait_cnt == WAIT_LAST) begin
                        state <= OCWS_RUN;
                    end
                end
                default: begin
                    state <= OCWS_CAPTURE;
                end
            endcase
        end
    end

    // Gate drive, trip and retry pulses
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            gate <= '0;
            overcurrent_trip_o <= 1'b0;
            retry_start_o <= 1'b0;
        end else begin
            overcurrent_trip_o <= trip_hit;
            retry_start_o <= (state == OCWS_WAIT) && ss_step_i && (wait_cnt == WAIT_LAST);
            case (state)
                // Follow the PWM while switching; high side held off while awaiting the half pulse
                OCWS_RUN, OCWS_FINISH, OCWS_HALF_ARM: begin
                    gate.hs <= pwm_on_i && state != OCWS_HALF_ARM;
                    gate.ls <= !pwm_on_i;
                end
                // High side on for half of the last on-time
                OCWS_HALF: begin
                    gate.hs <= !half_done;
                    gate.ls <= half_done;
                end
                // Gates off during capture and retry wait
                default: begin
                    gate <= '0;
                end
            endcase
        end
    end

    // Trip reference, doubled during soft-start
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            trip_ref_o <= '0;
        end else if (ss_active_i) begin
            trip_ref_o <= {code, 1'b0};
        end else begin
            trip_ref_o <= {1'b0, code};
        end
    end

    assign hs_gate_o = gate.hs;
    assign ls_gate_o = gate.ls;
    assign set_dac_o = dac_cnt;
    assign trip_setting_code_o = code;
    assign window_limit_o = window_limit;

    // Turn-on: one off cycle followed by one on cycle
    sequence s_turn_on;
        !pwm_on_i ##1 pwm_on_i;
    endsequence

    chk_tick_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_turn_on |=> on_ticks == TICK_INC)
        else $error("tick counter not cleared at turn-on");
    chk_window_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (pwm_fall && state != OCWS_HALF) |=> window_limit == ocws_three_quarter($past(on_ticks)))
        else $error("window limit not three quarters of on-time");
    chk_window_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (pwm_on_i && on_ticks >= window_limit) |=> !overcurrent_trip_o)
        else $error("trip accepted outside window");
    chk_trip_fault: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state == OCWS_RUN && in_window && sense_s) |=> overcurrent_trip_o && state == OCWS_FINISH)
        else $error("trip not flagged in window");
    chk_ref_double: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ss_active_i |=> trip_ref_o == {$past(code), 1'b0})
        else $error("reference not doubled in soft-start");
    chk_ref_normal: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !ss_active_i |=> trip_ref_o == {1'b0, $past(code)})
        else $error("reference not restored after soft-start");
    chk_half_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state == OCWS_HALF_ARM && pwm_on_i) |=> state == OCWS_HALF ##1 hs_gate_o || state == OCWS_WAIT)
        else $error("half pulse missing after trip");
    chk_wait_off: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state == OCWS_WAIT && $past(state) == OCWS_WAIT) |-> !hs_gate_o && !ls_gate_o)
        else $error("gate on during retry wait");
    chk_retry_count: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        retry_start_o |-> $past(wait_cnt) == WAIT_LAST)
        else $error("retry before four soft-starts");
    chk_code_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        state != OCWS_CAPTURE |=> $stable(code))
        else $error("trip code changed after capture");
endmodule

// File: ocws_power_stage.sv
// Model of the external switch stage, the set comparator and the sense comparator
module ocws_power_stage
    import ocws_pkg::*;
(
    input wire logic core_clk_i,              // Core clock
    input wire logic hs_gate_i,               // High-side gate from the sequencer
    input wire logic [CODE_W-1:0] set_dac_i,  // Capture ramp code
    input wire logic [CODE_W-1:0] set_level_i, // Code where the set resistor level sits
    input wire logic overload_i,              // Inductor current above the trip level
    input wire logic [31:0] fault_at_i,       // Cycles into the on-time before overload shows
    output logic set_cmp_o,                   // Set comparator output
    output logic sense_cmp_o                  // Switch node above trip reference
);
    timeunit 1ns;
    timeprecision 1ns;
    int on_cnt; // Cycles since the high side closed

    // Count on-time cycles so the overload can appear late or early in a pulse
    always_ff @(posedge core_clk_i) begin
        if (!hs_gate_i) begin
            on_cnt <= 0;
        end else begin
            on_cnt <= on_cnt + 1;
        end
    end

    // Set comparator trips once the ramp reaches the resistor level
    assign set_cmp_o = (set_dac_i >= set_level_i);
    // Sensing only means something while the high side conducts; low otherwise
    assign sense_cmp_o = hs_gate_i && overload_i && (on_cnt >= int'(fault_at_i));
endmodule

// File: ocws_top_tb.sv
// Self-checking bench for the overcurrent window sequencer
module ocws_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ocws_pkg::*;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic pwm_on_i = 1'b0;
    logic ss_active_i = 1'b0;
    logic ss_step_i = 1'b0;
    logic overload = 1'b0;                 // Overload shown by the stage model
    logic [CODE_W-1:0] set_level = 6'h14;  // Resistor level as a code
    logic set_cmp, sense_cmp, hs, ls, trip, retry;
    logic [REF_W-1:0] trip_ref;
    logic [CODE_W-1:0] set_dac, code;
    logic [TICK_W-1:0] win;
    logic [31:0] fault_at = 32'h0;         // Overload delay handed to the stage model
    int ton_q[$];                          // Demanded on-times, in clocks, oldest first
    int hs_base = 0;                       // High-side count at the start of a scenario
    int n_errors = 0;
    int n_compared = 0;
    int hs_cnt = 0;                        // High-side cycles seen
    int trip_cnt = 0;                      // Trip pulse cycles seen
    int retry_cnt = 0;                     // Retry pulse cycles seen
    int on_len;
    bit follow = 1'b0;                     // Gates should track demand
    logic prev_pwm = 1'b0;                 // Demand seen at the previous edge
    logic [31:0] rng = 32'h47fee0fe;

    ocws_top u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .pwm_on_i(pwm_on_i),
        .sense_cmp_i(sense_cmp), .set_cmp_i(set_cmp), .ss_active_i(ss_active_i),
        .ss_step_i(ss_step_i), .hs_gate_o(hs), .ls_gate_o(ls), .trip_ref_o(trip_ref),
        .set_dac_o(set_dac), .trip_setting_code_o(code), .window_limit_o(win),
        .overcurrent_trip_o(trip), .retry_start_o(retry));
    ocws_power_stage u_stage (.core_clk_i(core_clk_i), .hs_gate_i(hs), .set_dac_i(set_dac),
        .set_level_i(set_level), .overload_i(overload), .fault_at_i(fault_at),
        .set_cmp_o(set_cmp), .sense_cmp_o(sense_cmp));

    // Free-running core clock
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end

    // Next pseudo-random value
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Report and end the run
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One demand pulse, then an off gap
    task automatic pwm_pulse(input int on, input int off);
        ton_q.push_back(on);
        pwm_on_i <= 1'b1;
        repeat (on) @(posedge core_clk_i);
        pwm_on_i <= 1'b0;
        repeat (off) @(posedge core_clk_i);
    endtask

    // Demand as the design sampled it at the last rising edge
    always @(posedge core_clk_i) begin
        prev_pwm <= pwm_on_i;
    end

    // Gate tracking and pulse counting mid-cycle, where the outputs have settled
    always @(negedge core_clk_i) begin
        if (follow) begin
            check(hs, prev_pwm);
            check(ls, !prev_pwm);
        end
        hs_cnt += int'(hs);
        trip_cnt += int'(trip);
        retry_cnt += int'(retry);
    end

    // Cut a hang short
    initial begin
        #3000000;
        n_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (60) @(posedge core_clk_i);
        // Captured code lands just past the resistor level
        check((code >= 6'h14) && (code <= 6'h18), 32'h1);
        // Ramp stops two synchroniser stages past the crossing
        check(code, set_level + 6'h02);
        check(set_dac, set_level + 6'h02);
        // Doubled reference in soft-start, plain afterwards
        ss_active_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        check(trip_ref, {code, 1'b0});
        ss_active_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        check(trip_ref, {1'b0, code});
        // Random on-times: window is three quarters of the ticks
        follow = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            on_len = 3 + int'(rng % 38);
            pwm_pulse(on_len, 6);
            check(win, ton_q[$] * (CLK_PERIOD_NS / TICK_NS) * 3 / 4);
        end
        pwm_pulse(40, 6);
        check(win, 300);
        // Overload after the window closes is ignored
        overload <= 1'b1;
        fault_at <= 32'h22;
        pwm_pulse(40, 6);
        check(trip_cnt, 0);
        // Overload early in the window trips once
        fault_at <= 32'h4;
        pwm_pulse(40, 20);
        check(trip_cnt, 1);
        overload <= 1'b0;
        // Next pulse is cut to half the last on-time
        follow = 1'b0;
        hs_base = hs_cnt;
        pwm_pulse(40, 20);
        check(hs_cnt - hs_base, 20);
        // Gates stay off until the last of four soft-starts of steps
        for (int i = 0; i < 128; i++) begin
            check(retry_cnt, 0);
            check(hs, 1'b0);
            check(ls, 1'b0);
            ss_step_i <= 1'b1;
            @(posedge core_clk_i);
            ss_step_i <= 1'b0;
            rng = xs(rng);
            repeat (1 + int'(rng % 3)) @(posedge core_clk_i);
        end
        repeat (3) @(posedge core_clk_i);
        check(retry_cnt, 1);
        // Switching resumes after the retry
        follow = 1'b1;
        pwm_pulse(10, 6);
        // Mid-run reset, then a capture that runs to the top of the ramp
        follow = 1'b0;
        rstn_i <= 1'b0;
        set_level <= CODE_MAX;
        repeat (4) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (70) @(posedge core_clk_i);
        check(code, CODE_MAX);
        check(set_dac, CODE_MAX);
        check(trip_ref, {1'b0, CODE_MAX});
        print_verdict();
    end
endmodule
